// *** src/send_error_consts.vh ***
// Constants for the send-side error reporter: event codes, characters, timing.
// Assumes nothing; definitions only.
`ifndef SEND_ERROR_CONSTS_VH
`define SEND_ERROR_CONSTS_VH
`define EV_CLASS_SEND 8'h07
`define EV_FIRST_REPEAT 8'h01
`define EV_SETUP_ERROR 8'h02
`define EV_ACK_TIMEOUT 8'h03
`define EV_PARTNER_ABORT 8'h04
`define EV_NAK_SENDING 8'h05
`define EV_END_ERROR 8'h06
`define EV_END_TIMEOUT 8'h07
`define EV_FLOW_TIMEOUT 8'h08
`define EV_SETUP_EXCEEDED 8'h09
`define EV_XFER_EXCEEDED 8'h0A
`define EV_CONFLICT_HIGH 8'h0B
`define EV_CONFLICT_LOW 8'h0C
`define EV_NONE 8'h00
`define CH_STX 8'h02
`define CH_ETX 8'h03
`define CH_DLE 8'h10
`define CH_NAK 8'h15
`define CLK_MHZ 50
`define ACK_DELAY_US 2000
`define FLOW_WAIT_US 20000
`define US_PER_MS_TICK 1
`define ATTEMPTS_SETUP 6
`define ATTEMPTS_XFER 6
`endif

// *** src/wait_timer.v ***
// Down-counting timeout timer with restart and expiry pulse.
// Assumes a single clock; start reloads, stop halts.
`timescale 1ns/1ps
`default_nettype none
module wait_timer #(
  parameter WIDTH = 24
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_in,
  // Control
  input wire start_in,
  input wire stop_in,
  input wire [WIDTH-1:0] load_in,
  // Status
  output reg expired_out
);
  reg [WIDTH-1:0] count;
  reg running;
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count <= {WIDTH{1'b0}};
      running <= 1'b0;
      expired_out <= 1'b0;
    end else begin
      expired_out <= 1'b0;
      if (start_in) begin
        count <= load_in;
        running <= 1'b1;
      end else if (stop_in) begin
        running <= 1'b0;
      end else if (running) begin
        if (count == {WIDTH{1'b0}}) begin
          running <= 1'b0;
          expired_out <= 1'b1;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** src/serial_send_error_reporter.v ***
// Send-side error detection and event reporting for a framed serial link.
// Assumes the transmitter and receiver of the link sit on clock_in and give
// one-cycle strobes; only pin-level inputs (CTS) are synchronised here.
// Operation
// - Every send failure reports event class seven.
// - On fault or NAK, request repeat and report informational first repeat.
// - When repeats run out, report the first error seen in the transfer.
// - After STX, NAK or foreign character flags setup error.
// - Partner must answer STX within acknowledgment delay, else timeout.
// - Characters received during sending mean termination by partner.
// - NAK received while sending a frame reports its own event.
// - At end, NAK or non-DLE answer reports end-of-connection error.
// - DLE arriving before release completes also reports end error.
// - Partner must answer DLE ETX within acknowledgment delay, else timeout.
// - ASCII mode flow wait for XON or CTS expiring reports error.
// - Exceeding permitted setup attempts reports setup failure.
// - Exceeding permitted transfer attempts reports transfer failure.
// - Simultaneous start with both high priority reports conflict.
// - Simultaneous start with both low priority reports own conflict.
`include "send_error_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module serial_send_error_reporter #(
  parameter ACK_CYCLES = `ACK_DELAY_US * `CLK_MHZ,
  parameter FLOW_CYCLES = `FLOW_WAIT_US * `CLK_MHZ,
  parameter SETUP_TRIES = `ATTEMPTS_SETUP,
  parameter XFER_TRIES = `ATTEMPTS_XFER
) (
  // Clock and reset
  input wire clock_in,
  input wire rst_in,
  // Mode and configuration
  input wire ascii_mode_in,
  input wire high_prio_in,
  // Transmit sequencer strobes
  input wire send_req_in,
  input wire stx_sent_in,
  input wire data_start_in,
  input wire data_fault_in,
  input wire release_start_in,
  input wire release_done_in,
  // Received characters from partner
  input wire rx_valid_in,
  input wire [7:0] rx_char_in,
  // ASCII flow control
  input wire xon_in,
  input wire cts_pin_in,
  input wire flow_wait_in,
  // Results
  output reg repeat_out,
  output reg done_out,
  output reg fail_out,
  output reg event_valid_out,
  output reg [15:0] event_word_out
);
  localparam S_IDLE = 6'h01;
  localparam S_SETUP = 6'h02;
  localparam S_DATA = 6'h04;
  localparam S_REL = 6'h08;
  localparam S_END = 6'h10;
  localparam S_FLOW = 6'h20;
  localparam TW = 24;
  localparam [TW-1:0] ACK_LOAD = ACK_CYCLES;
  localparam [TW-1:0] FLOW_LOAD = FLOW_CYCLES;
  localparam [3:0] SETUP_MAX = SETUP_TRIES;
  localparam [3:0] XFER_MAX = XFER_TRIES;

  reg [5:0] state;
  reg [5:0] next_state;
  reg [3:0] setup_count;
  reg [3:0] xfer_count;
  reg [7:0] first_err;
  reg repeated;
  reg cts_meta;
  reg cts_sync;
  reg ack_start;
  reg flow_start;
  reg stop_timers;
  reg [7:0] next_err;
  reg err_hit;
  reg setup_phase;
  wire ack_expired;
  wire flow_expired;
  wire flow_ok;
  wire [7:0] first_cause;
  reg [7:0] pend_limit;

  // CTS comes straight from a pin
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cts_meta <= 1'b0;
      cts_sync <= 1'b0;
    end else begin
      cts_meta <= cts_pin_in;
      cts_sync <= cts_meta;
    end
  end
  assign flow_ok = xon_in | cts_sync;
  // A job that fails on its only attempt has no stored cause yet
  assign first_cause = (first_err == `EV_NONE) ? next_err : first_err;

  wait_timer #(.WIDTH(TW)) ack_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .start_in(ack_start),
    .stop_in(stop_timers),
    .load_in(ACK_LOAD),
    .expired_out(ack_expired)
  );
  wait_timer #(.WIDTH(TW)) flow_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .start_in(flow_start),
    .stop_in(stop_timers),
    .load_in(FLOW_LOAD),
    .expired_out(flow_expired)
  );

  // Error classification per state
  always @* begin
    next_state = state;
    next_err = `EV_NONE;
    err_hit = 1'b0;
    setup_phase = 1'b0;
    ack_start = 1'b0;
    flow_start = 1'b0;
    stop_timers = 1'b0;
    case (state)
      S_IDLE: begin
        if (send_req_in && ascii_mode_in) begin
          next_state = S_FLOW;
          flow_start = 1'b1;
        end else if (stx_sent_in) begin
          next_state = S_SETUP;
          ack_start = 1'b1;
        end
      end
      S_FLOW: begin
        if (flow_expired) begin
          next_err = `EV_FLOW_TIMEOUT;
          err_hit = 1'b1;
        end else if (flow_ok || !flow_wait_in) begin
          stop_timers = 1'b1;
          next_state = S_IDLE;
        end
      end
      S_SETUP: begin
        setup_phase = 1'b1;
        if (rx_valid_in) begin
          stop_timers = 1'b1;
          if (rx_char_in == `CH_DLE) begin
            next_state = S_DATA;
          end else if (rx_char_in == `CH_STX) begin
            // Both stations started: priority decides
            if (high_prio_in) begin
              next_err = `EV_CONFLICT_HIGH;
            end else begin
              next_err = `EV_CONFLICT_LOW;
            end
            err_hit = 1'b1;
          end else begin
            next_err = `EV_SETUP_ERROR;
            err_hit = 1'b1;
          end
        end else if (ack_expired) begin
          next_err = `EV_ACK_TIMEOUT;
          err_hit = 1'b1;
        end
      end
      S_DATA: begin
        if (rx_valid_in) begin
          if (rx_char_in == `CH_NAK) begin
            next_err = `EV_NAK_SENDING;
          end else if (rx_char_in == `CH_DLE) begin
            next_err = `EV_END_ERROR;
          end else begin
            next_err = `EV_PARTNER_ABORT;
          end
          err_hit = 1'b1;
        end else if (data_fault_in) begin
          next_err = `EV_PARTNER_ABORT;
          err_hit = 1'b1;
        end else if (release_start_in) begin
          next_state = S_REL;
        end
      end
      S_REL: begin
        if (rx_valid_in) begin
          next_err = `EV_END_ERROR;
          err_hit = 1'b1;
        end else if (release_done_in) begin
          next_state = S_END;
          ack_start = 1'b1;
        end
      end
      S_END: begin
        if (rx_valid_in) begin
          stop_timers = 1'b1;
          if (rx_char_in == `CH_DLE) begin
            next_state = S_IDLE;
          end else begin
            next_err = `EV_END_ERROR;
            err_hit = 1'b1;
          end
        end else if (ack_expired) begin
          next_err = `EV_END_TIMEOUT;
          err_hit = 1'b1;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      setup_count <= 4'h0;
      xfer_count <= 4'h0;
      first_err <= `EV_NONE;
      repeated <= 1'b0;
      repeat_out <= 1'b0;
      done_out <= 1'b0;
      fail_out <= 1'b0;
      event_valid_out <= 1'b0;
      event_word_out <= 16'h0000;
      pend_limit <= `EV_NONE;
    end else begin
      repeat_out <= 1'b0;
      done_out <= 1'b0;
      fail_out <= 1'b0;
      event_valid_out <= 1'b0;
      state <= next_state;
      pend_limit <= `EV_NONE;
      if (pend_limit != `EV_NONE) begin
        // Limit word trails the first-cause word so the host sees both
        fail_out <= 1'b1;
        event_valid_out <= 1'b1;
        event_word_out <= {`EV_CLASS_SEND, pend_limit};
      end
      if (state == S_IDLE && (send_req_in || stx_sent_in) &&
          next_state != S_FLOW && first_err == `EV_NONE &&
          !repeated) begin
        setup_count <= 4'h0;
        xfer_count <= 4'h0;
      end
      if (state == S_END && next_state == S_IDLE) begin
        done_out <= 1'b1;
        first_err <= `EV_NONE;
        repeated <= 1'b0;
        setup_count <= 4'h0;
        xfer_count <= 4'h0;
      end
      if (err_hit) begin
        state <= S_IDLE;
        event_valid_out <= 1'b1;
        if (state == S_FLOW) begin
          // Flow wait expiry has no repetition
          fail_out <= 1'b1;
          event_word_out <= {`EV_CLASS_SEND, next_err};
        end else if (next_err == `EV_CONFLICT_HIGH ||
                     next_err == `EV_CONFLICT_LOW) begin
          fail_out <= 1'b1;
          first_err <= `EV_NONE;
          repeated <= 1'b0;
          event_word_out <= {`EV_CLASS_SEND, next_err};
        end else if (setup_phase && setup_count + 4'h1 >= SETUP_MAX) begin
          first_err <= `EV_NONE;
          repeated <= 1'b0;
          pend_limit <= `EV_SETUP_EXCEEDED;
          event_word_out <= {`EV_CLASS_SEND, first_cause};
        end else if (!setup_phase && xfer_count + 4'h1 >= XFER_MAX) begin
          first_err <= `EV_NONE;
          repeated <= 1'b0;
          pend_limit <= `EV_XFER_EXCEEDED;
          event_word_out <= {`EV_CLASS_SEND, first_cause};
        end else begin
          // Retry; the failure word later names the first cause
          repeat_out <= 1'b1;
          repeated <= 1'b1;
          if (first_err == `EV_NONE) begin
            first_err <= next_err;
          end
          if (setup_phase) begin
            setup_count <= setup_count + 4'h1;
          end else begin
            xfer_count <= xfer_count + 4'h1;
          end
          if (!repeated) begin
            event_word_out <= {`EV_CLASS_SEND, `EV_FIRST_REPEAT};
          end else begin
            event_valid_out <= 1'b0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** test/send_error_checker_sva.sv ***
// Checker on the ports of the send-side error reporter.
// Assumes one clock, asynchronous active-high reset, one-cycle result pulses.
`timescale 1ns/1ps
`default_nettype none
module send_error_checker (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Inputs watched
  input wire logic ascii_mode_in,
  input wire logic high_prio_in,
  input wire logic stx_sent_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_char_in,
  // Results
  input wire logic repeat_out,
  input wire logic done_out,
  input wire logic fail_out,
  input wire logic event_valid_out,
  input wire logic [15:0] event_word_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence nak_after_stx;
    !ascii_mode_in && stx_sent_in ##1 !rx_valid_in ##1
      rx_valid_in && rx_char_in == 8'h15;
  endsequence
  sequence foreign_in_data;
    stx_sent_in ##1 !rx_valid_in ##1 rx_valid_in && rx_char_in == 8'h10
      ##1 (!rx_valid_in) [*2] ##1 rx_valid_in && rx_char_in == 8'h41;
  endsequence
  class_seven_a: assert property (event_valid_out |->
    event_word_out[15:8] == 8'h07) else $error("event class wrong");
  first_repeat_a: assert property (repeat_out && event_valid_out |->
    event_word_out == 16'h0701) else $error("repeat word wrong");
  fail_word_a: assert property (fail_out |-> event_valid_out)
    else $error("give-up without event");
  setup_nak_a: assert property (nak_after_stx |=>
    repeat_out || event_valid_out) else $error("setup NAK not acted on");
  partner_abort_a: assert property (foreign_in_data |=>
    repeat_out || event_valid_out) else $error("foreign char ignored");
  limit_after_cause_a: assert property (fail_out &&
    event_word_out[7:0] inside {8'h09, 8'h0A} |-> $past(event_valid_out))
    else $error("limit word without first cause");
  conflict_high_a: assert property (event_valid_out &&
    event_word_out[7:0] == 8'h0B |-> fail_out && $past(high_prio_in))
    else $error("high conflict wrong");
  conflict_low_a: assert property (event_valid_out &&
    event_word_out[7:0] == 8'h0C |-> fail_out && !$past(high_prio_in))
    else $error("low conflict wrong");
  flow_word_a: assert property (event_valid_out &&
    event_word_out[7:0] == 8'h08 |-> fail_out && $past(ascii_mode_in))
    else $error("flow event wrong");
  word_hold_a: assert property (!event_valid_out |->
    $stable(event_word_out)) else $error("event word moved");
endmodule
`default_nettype wire

// *** test/link_partner.sv ***
// Behavioural partner controller on the serial line, one char per call.
// Assumes the bench calls answer() between its own strobes.
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  // Clock
  input wire logic clock_in,
  // Characters towards the block
  output logic rx_valid_out,
  output logic [7:0] rx_char_out
);
  initial begin
    rx_valid_out = 1'b0;
    rx_char_out = 8'hFF;
  end
  // Gap is kept below the acknowledgment delay by the caller
  task automatic answer(input logic [7:0] c, input int gap);
    repeat (gap) @(negedge clock_in);
    @(negedge clock_in);
    rx_valid_out = 1'b1;
    rx_char_out = c;
    @(negedge clock_in);
    rx_valid_out = 1'b0;
    // Inverted so a stale char is never mistaken for a fresh one
    rx_char_out = ~c;
  endtask
endmodule
`default_nettype wire

// *** test/serial_send_error_reporter_test.sv ***
// Self-checking bench for the send-side error reporter.
// Assumes send_error_consts.vh on the include path; short timer counts.
`include "send_error_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module serial_send_error_reporter_test;
  localparam int ACK = 20;
  localparam int FLOW = 30;
  localparam int TRIES = 3;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic ascii_mode = 1'b0;
  logic high_prio = 1'b0;
  logic flow_wait = 1'b0;
  logic xon = 1'b0;
  logic cts = 1'b0;
  logic [4:0] strb = 5'h00;
  wire rx_valid;
  wire [7:0] rx_char;
  wire rep;
  wire done;
  wire give;
  wire ev;
  wire [15:0] word;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [15:0] n_rep, n_done, n_give, n_ev, last_word, prev_word;
  serial_send_error_reporter #(.ACK_CYCLES(ACK), .FLOW_CYCLES(FLOW),
    .SETUP_TRIES(TRIES), .XFER_TRIES(TRIES)) DUT (.clock_in(clock_in),
    .rst_in(rst_in), .ascii_mode_in(ascii_mode), .high_prio_in(high_prio),
    .send_req_in(strb[0]), .stx_sent_in(strb[1]), .data_start_in(1'b0),
    .data_fault_in(strb[2]), .release_start_in(strb[3]),
    .release_done_in(strb[4]), .rx_valid_in(rx_valid), .rx_char_in(rx_char),
    .xon_in(xon), .cts_pin_in(cts), .flow_wait_in(flow_wait),
    .repeat_out(rep), .done_out(done), .fail_out(give),
    .event_valid_out(ev), .event_word_out(word));
  link_partner peer (.clock_in(clock_in), .rx_valid_out(rx_valid),
    .rx_char_out(rx_char));
  initial begin
    forever #10 clock_in = ~clock_in;
  end
  // Sampled at posedge so the design's updates of that edge are not seen
  always @(posedge clock_in) begin
    cyc++;
    n_rep += rep;
    n_done += done;
    n_give += give;
    n_ev += ev;
    if (ev) begin
      prev_word = last_word;
      last_word = word;
    end
    // Whole run needs well under a thousand cycles
    if (cyc == 5000) begin
      n_fail++;
      close_out;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic pulse(input int b);
    @(negedge clock_in);
    strb[b] = 1'b1;
    @(negedge clock_in);
    strb[b] = 1'b0;
  endtask
  task automatic clear;
    repeat (3) @(negedge clock_in);
    {n_rep, n_done, n_give, n_ev, last_word, prev_word} = '0;
  endtask
  task automatic frame(input int gap);
    pulse(1);
    peer.answer(`CH_DLE, 0);
    pulse(3);
    pulse(4);
    peer.answer(`CH_DLE, gap);
    repeat (3) @(negedge clock_in);
  endtask
  task automatic t_setup_nak;
    clear;
    for (int i = 1; i <= TRIES; i++) begin
      pulse(1);
      peer.answer(`CH_NAK, 0);
      repeat (2) @(negedge clock_in);
      if (i == 1) check(last_word, 16'h0701);
    end
    check(n_rep, 16'(TRIES - 1));
    check(n_ev, 16'h0003);
    check(prev_word, 16'h0702);
    check({n_give[7:0], last_word[7:0]}, 16'h0109);
    $display("setup NAK test done");
  endtask
  task automatic t_xfer;
    clear;
    for (int i = 1; i <= TRIES; i++) begin
      pulse(1);
      peer.answer(`CH_DLE, 0);
      if (i == 1) pulse(2);
      else peer.answer(`CH_NAK, 1);
      repeat (2) @(negedge clock_in);
    end
    check(n_rep, 16'(TRIES - 1));
    check({n_give[7:0], last_word[7:0]}, 16'h010A);
    check(prev_word, 16'h0704);
    $display("transfer limit test done");
  endtask
  task automatic t_ack_limit;
    clear;
    for (int i = 0; i < TRIES; i++) begin
      pulse(1);
      repeat (ACK + 4) @(negedge clock_in);
    end
    check({n_rep[7:0], prev_word[7:0]}, 16'h0203);
    check({n_give[7:0], last_word[7:0]}, 16'h0109);
    $display("setup timeout limit test done");
  endtask
  task automatic t_end_nak;
    clear;
    for (int i = 0; i < TRIES; i++) begin
      pulse(1);
      peer.answer(`CH_DLE, 0);
      pulse(3);
      pulse(4);
      peer.answer(`CH_NAK, 0);
      repeat (2) @(negedge clock_in);
    end
    check({n_rep[7:0], prev_word[7:0]}, 16'h0206);
    check({n_give[7:0], last_word[7:0]}, 16'h010A);
    $display("end NAK limit test done");
  endtask
  task automatic t_timeout;
    clear;
    pulse(1);
    repeat (ACK - 1) @(negedge clock_in);
    check(n_rep, 16'h0000);
    repeat (6) @(negedge clock_in);
    check(n_rep, 16'h0001);
    pulse(1);
    peer.answer(`CH_DLE, 0);
    pulse(3);
    pulse(4);
    repeat (ACK - 1) @(negedge clock_in);
    check(n_rep, 16'h0001);
    repeat (6) @(negedge clock_in);
    check(n_rep, 16'h0002);
    frame(ACK - 6);
    check(n_done, 16'h0001);
    $display("timeout test done");
  endtask
  task automatic t_early;
    clear;
    pulse(1);
    peer.answer(`CH_DLE, 0);
    peer.answer(8'h41, 1);
    pulse(1);
    peer.answer(`CH_DLE, 0);
    pulse(3);
    peer.answer(`CH_DLE, 0);
    repeat (3) @(negedge clock_in);
    check(n_rep, 16'h0002);
    frame(0);
    check({n_done[7:0], n_give[7:0]}, 16'h0100);
    $display("early answer test done");
  endtask
  task automatic t_conflict;
    for (int p = 0; p < 2; p++) begin
      high_prio = p[0];
      clear;
      pulse(1);
      peer.answer(`CH_STX, 0);
      repeat (3) @(negedge clock_in);
      check(last_word, p ? 16'h070B : 16'h070C);
    end
    $display("conflict test done");
  endtask
  task automatic t_flow;
    ascii_mode = 1'b1;
    flow_wait = 1'b1;
    clear;
    pulse(0);
    repeat (FLOW - 1) @(negedge clock_in);
    check(n_give, 16'h0000);
    repeat (6) @(negedge clock_in);
    check({n_give[7:0], last_word[7:0]}, 16'h0108);
    // CTS goes through the pin synchroniser, XON does not
    for (int p = 1; p < 3; p++) begin
      {xon, cts} = p[1:0];
      pulse(0);
      repeat (FLOW + 6) @(negedge clock_in);
      check(n_give, 16'h0001);
    end
    {xon, cts} = 2'b00;
    flow_wait = 1'b0;
    ascii_mode = 1'b0;
    $display("flow wait test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clock_in);
    rst_in = 1'b0;
    t_setup_nak;
    t_ack_limit;
    t_xfer;
    t_end_nak;
    t_timeout;
    t_early;
    t_conflict;
    t_flow;
    close_out;
  end
endmodule
bind serial_send_error_reporter send_error_checker chk (
  .clock_in(clock_in), .rst_in(rst_in), .ascii_mode_in(ascii_mode_in),
  .high_prio_in(high_prio_in), .stx_sent_in(stx_sent_in),
  .rx_valid_in(rx_valid_in), .rx_char_in(rx_char_in),
  .repeat_out(repeat_out), .done_out(done_out), .fail_out(fail_out),
  .event_valid_out(event_valid_out), .event_word_out(event_word_out));
`default_nettype wire
